// ### iisc_pkg.sv
// Constants, field layout and carrier types of the two-wire unit's
// interrupt, sleep and synchronisation logic.
// Assumes a single 100 MHz clock; addresses are the printed byte offsets.
//
// Summary of operation
// - Slave: error, ready, address, stop interrupts
// - Master: error, slave-bus, master-bus interrupts
// - Flag bit set when its condition occurs
// - Enable-set ones enable, enable-clear ones disable
// - Request while any enabled flag set
// - Request holds until clear, disable, reset
// - One shared request line; software reads flags
// - Master keeps core clock in idle
// - Master run-in-standby keeps clock, interrupts wake
// - Master standby stops clock after transaction
// - Slave run-in-standby lets address match wake
// - Slave standby without run drops receptions
// - Busy bit set at start, cleared at end
// - Synchronised write while its busy bit set gives bus error
// - Soft reset write synchronised, reset busy high
// - Enable write synchronised, enable busy high
// - Line state, master address/data writes synchronised
package iisc_pkg;

    localparam logic [5:0] OFS_CTRL_MAIN = 6'h00;
    localparam logic [5:0] OFS_CTRL_SEC  = 6'h04;
    localparam logic [5:0] OFS_EN_CLR    = 6'h14;
    localparam logic [5:0] OFS_EN_SET    = 6'h16;
    localparam logic [5:0] OFS_FLAGS     = 6'h18;
    localparam logic [5:0] OFS_STATUS    = 6'h1A;
    localparam logic [5:0] OFS_SYNC      = 6'h1C;
    localparam logic [5:0] OFS_ADDR      = 6'h24;
    localparam logic [5:0] OFS_DATA      = 6'h28;

    localparam int CM_SOFT_RESET    = 0;
    localparam int CM_ENABLE   = 1;
    localparam int CM_MODE_LO  = 2;
    localparam int CM_RUN_IN_STANDBY = 7;
    localparam logic [2:0] MODE_SLAVE  = 3'h4;
    localparam logic [2:0] MODE_MASTER = 3'h5;

    localparam int FL_ERROR  = 7;
    localparam int FL_BYTE_READY_FLAG   = 2;
    localparam int FL_ADDR_HIT_FLAG = 1;
    localparam int FL_STOP_SEEN_FLAG   = 0;
    localparam int FL_SB     = 1;
    localparam int FL_MB     = 0;

    localparam int ST_LINE_LO = 4;
    localparam int SB_SOFT_RESET   = 0;
    localparam int SB_ENABLE  = 1;
    localparam int SB_SYSTEM_OP_BUSY   = 2;

    localparam int          SYNC_CYCLES = 4;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE    = 8'h00;

    typedef struct packed {
        logic error;
        logic byte_ready_flag;
        logic addr_hit_flag;
        logic stop_seen_flag;
        logic slave_side_bus_flag;
        logic master_side_bus_flag;
    } iisc_evt_t;

    typedef struct packed {
        logic idle;
        logic standby;
        logic xfer_busy;
    } iisc_sleep_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_LINE = 2'b01,
        OP_ADDR = 2'b11,
        OP_DATA = 2'b10
    } iisc_op_t;

    typedef enum logic [1:0] {
        CK_RUN   = 2'b00,
        CK_DRAIN = 2'b01,
        CK_STOP  = 2'b11
    } iisc_ck_t;

endpackage

// ### iisc_ctrl.sv
// Interrupt flags, sleep clock request and write synchronisation of the
// two-wire unit.
// Assumes the protocol engine delivers one-cycle event pulses and that
// the core-domain crossing is modelled as a fixed SYNC_LEN cycle delay.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module iisc_ctrl #(
    parameter int SYNC_LEN = iisc_pkg::SYNC_CYCLES
) (
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [5:0]        reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    input  wire logic              reg_we_i,
    input  wire logic              reg_re_i,
    output logic      [31:0]       reg_rdata_o,
    output logic                   bus_err_o,
    input  wire iisc_pkg::iisc_evt_t   evt_i,
    input  wire iisc_pkg::iisc_sleep_t sleep_i,
    input  wire logic [15:0]       status_i,
    input  wire logic [7:0]        rx_data_i,
    output logic                   irq_o,
    output logic                   wake_o,
    output logic                   core_clock_req_o,
    output logic                   rx_drop_o,
    output logic                   enabled_o,
    output logic [31:0]            control_main_o,
    output logic [31:0]            control_sec_o,
    output logic [31:0]            addr_o,
    output logic [15:0]            data_o,
    output logic [1:0]             line_state_field_o,
    output logic                   system_op_busy_apply_o,
    output iisc_pkg::iisc_op_t     system_op_busy_kind_o
);

    localparam int CW = $clog2(SYNC_LEN + 1);

    logic [31:0]        ctrl_r;
    logic [31:0]        ctrl2_r;
    logic               enable_r;
    logic               enable_pend_r;
    logic [7:0]         flags_r;
    logic [7:0]         flags_nxt;
    logic [7:0]         en_r;
    logic [7:0]         en_nxt;
    logic [2:0][CW-1:0] cnt_r;
    logic [31:0]        addr_r;
    logic [15:0]        data_r;
    logic [1:0]         line_r;
    logic [31:0]        pend_val_r;
    iisc_pkg::iisc_op_t pend_op_r;
    logic [31:0]        rdata_r;
    logic               err_r;
    logic               irq_r;
    logic               wake_r;
    logic               clkreq_r;
    logic               drop_r;
    logic               apply_r;
    iisc_pkg::iisc_op_t apply_kind_r;
    iisc_pkg::iisc_ck_t ck_r;
    iisc_pkg::iisc_ck_t ck_nxt;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        return a == o;
    endfunction

    // Decoding
    wire [2:0] mode      = ctrl_r[iisc_pkg::CM_MODE_LO +: 3];
    wire       is_master = mode == iisc_pkg::MODE_MASTER;
    wire       is_slave  = mode == iisc_pkg::MODE_SLAVE;
    wire       run_in_standby  = ctrl_r[iisc_pkg::CM_RUN_IN_STANDBY];
    wire [2:0] busy;
    assign busy[0] = cnt_r[0] != '0;
    assign busy[1] = cnt_r[1] != '0;
    assign busy[2] = cnt_r[2] != '0;
    wire [2:0] done;
    assign done[0] = cnt_r[0] == CW'(1);
    assign done[1] = cnt_r[1] == CW'(1);
    assign done[2] = cnt_r[2] == CW'(1);
    wire soft_reset_done = done[iisc_pkg::SB_SOFT_RESET];

    wire w_ctrl   = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_CTRL_MAIN);
    wire w_ctrl2  = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_CTRL_SEC);
    wire w_enclr  = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_EN_CLR);
    wire w_enset  = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_EN_SET);
    wire w_flags  = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_FLAGS);
    wire w_status = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_STATUS);
    wire w_addr   = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_ADDR);
    wire w_data   = reg_we_i && hit(reg_addr_i, iisc_pkg::OFS_DATA);
    wire r_flags  = reg_re_i && hit(reg_addr_i, iisc_pkg::OFS_FLAGS);

    // Soft reset request wins over the enable part of the same write
    wire ctrl_rst  = w_ctrl && reg_wdata_i[iisc_pkg::CM_SOFT_RESET];
    wire ctrl_en   = w_ctrl && !reg_wdata_i[iisc_pkg::CM_SOFT_RESET];
    // A running soft reset blocks every synchronised access
    wire rst_block = busy[iisc_pkg::SB_SOFT_RESET];
    wire sys_wr    = w_status || (is_master && (w_addr || w_data));
    wire err_rst   = ctrl_rst && rst_block;
    wire err_en    = ctrl_en && (busy[iisc_pkg::SB_ENABLE] || rst_block);
    wire err_sys   = sys_wr && (busy[iisc_pkg::SB_SYSTEM_OP_BUSY] || rst_block);
    wire err_any   = err_rst || err_en || err_sys;
    wire go_rst    = ctrl_rst && !err_rst;
    wire go_en     = ctrl_en && !err_en;
    wire go_sys    = sys_wr && !err_sys;

    // Event routing by role
    wire [7:0] ev_slave = {evt_i.error, 4'h0, evt_i.byte_ready_flag,
                           evt_i.addr_hit_flag, evt_i.stop_seen_flag};
    wire [7:0] ev_master = {evt_i.error, 5'h00, evt_i.slave_side_bus_flag,
                            evt_i.master_side_bus_flag};
    wire [7:0] ev_set = is_slave ? ev_slave :
                        (is_master ? ev_master : 8'h00);
    // Read-to-clear and write-one-to-clear both apply; a set wins
    wire [7:0] fl_clr = (w_flags ? reg_wdata_i[7:0] : 8'h00)
                      | (r_flags ? 8'hFF : 8'h00);

    assign flags_nxt = soft_reset_done ? iisc_pkg::RST_BYTE
                     : (flags_r & ~fl_clr) | ev_set;
    assign en_nxt = soft_reset_done ? iisc_pkg::RST_BYTE
                  : (en_r | (w_enset ? reg_wdata_i[7:0] : 8'h00))
                    & ~(w_enclr ? reg_wdata_i[7:0] : 8'h00);
    // One shared line for every source
    wire irq_nxt = |(flags_nxt & en_nxt);

    // Sleep behaviour
    wire master_hold = is_master && sleep_i.standby && !run_in_standby;
    wire slave_hold  = is_slave && sleep_i.standby && !run_in_standby;
    always_comb begin
        ck_nxt = ck_r;
        case (ck_r)
            iisc_pkg::CK_RUN: begin
                if (master_hold) begin
                    ck_nxt = sleep_i.xfer_busy ? iisc_pkg::CK_DRAIN
                                               : iisc_pkg::CK_STOP;
                end else if (slave_hold) begin
                    ck_nxt = iisc_pkg::CK_STOP;
                end
            end
            iisc_pkg::CK_DRAIN: begin
                if (!master_hold) begin
                    ck_nxt = slave_hold ? iisc_pkg::CK_STOP
                                        : iisc_pkg::CK_RUN;
                end else if (!sleep_i.xfer_busy) begin
                    ck_nxt = iisc_pkg::CK_STOP;
                end
            end
            iisc_pkg::CK_STOP: begin
                if (!master_hold && !slave_hold) begin
                    ck_nxt = iisc_pkg::CK_RUN;
                end else if (master_hold && sleep_i.xfer_busy) begin
                    // A new transfer holds the clock until it ends
                    ck_nxt = iisc_pkg::CK_DRAIN;
                end
            end
            default: ck_nxt = iisc_pkg::CK_RUN;
        endcase
    end
    // Idle never stops the clock; standby stops it only via the FSM
    wire clkreq_nxt = ck_nxt != iisc_pkg::CK_STOP;
    wire in_sleep   = sleep_i.idle || sleep_i.standby;
    // A slave in standby wakes only on address match, and only with run on
    wire wake_nxt = !in_sleep ? 1'b0
                  : (is_slave && sleep_i.standby)
                    ? (run_in_standby && flags_nxt[iisc_pkg::FL_ADDR_HIT_FLAG]
                       && en_nxt[iisc_pkg::FL_ADDR_HIT_FLAG])
                    : irq_nxt;
    wire drop_nxt = slave_hold;

    // Read mux
    wire [31:0] sync_word = {29'h0, busy};
    wire [31:0] stat_word = {16'h0, status_i[15:6], line_r, status_i[3:0]};
    wire [31:0] ctrl_word = {ctrl_r[31:2], enable_r, 1'b0};
    wire [31:0] rd_mux =
        hit(reg_addr_i, iisc_pkg::OFS_CTRL_MAIN) ? ctrl_word :
        hit(reg_addr_i, iisc_pkg::OFS_CTRL_SEC)  ? ctrl2_r :
        hit(reg_addr_i, iisc_pkg::OFS_EN_CLR)    ? {24'h0, en_r} :
        hit(reg_addr_i, iisc_pkg::OFS_EN_SET)    ? {24'h0, en_r} :
        hit(reg_addr_i, iisc_pkg::OFS_FLAGS)     ? {24'h0, flags_r} :
        hit(reg_addr_i, iisc_pkg::OFS_STATUS)    ? stat_word :
        hit(reg_addr_i, iisc_pkg::OFS_SYNC)      ? sync_word :
        hit(reg_addr_i, iisc_pkg::OFS_ADDR)      ? addr_r :
        hit(reg_addr_i, iisc_pkg::OFS_DATA)      ? {24'h0, rx_data_i} :
        iisc_pkg::RST_WORD;

    // Synchronisation counters: busy from the write edge onward
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (cnt_r[i] != '0) begin
                    cnt_r[i] <= cnt_r[i] - CW'(1);
                end
            end
            if (go_rst) begin
                cnt_r[iisc_pkg::SB_SOFT_RESET] <= CW'(SYNC_LEN);
            end
            if (go_en) begin
                cnt_r[iisc_pkg::SB_ENABLE] <= CW'(SYNC_LEN);
            end
            if (go_sys) begin
                cnt_r[iisc_pkg::SB_SYSTEM_OP_BUSY] <= CW'(SYNC_LEN);
            end
        end
    end

    // Control registers
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r        <= iisc_pkg::RST_WORD;
            ctrl2_r       <= iisc_pkg::RST_WORD;
            enable_r      <= 1'b0;
            enable_pend_r <= 1'b0;
        end else if (soft_reset_done) begin
            ctrl_r        <= iisc_pkg::RST_WORD;
            ctrl2_r       <= iisc_pkg::RST_WORD;
            enable_r      <= 1'b0;
            enable_pend_r <= 1'b0;
        end else begin
            // Main control configuration bits are frozen while the unit is enabled; the secondary word is not
            if (go_en && !enable_r) begin
                ctrl_r <= {reg_wdata_i[31:2], 2'b00};
            end
            if (go_en) begin
                enable_pend_r <= reg_wdata_i[iisc_pkg::CM_ENABLE];
            end
            if (done[iisc_pkg::SB_ENABLE]) begin
                enable_r <= enable_pend_r;
            end
            if (w_ctrl2) begin
                ctrl2_r <= reg_wdata_i;
            end
        end
    end

    // Interrupt state
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_r <= iisc_pkg::RST_BYTE;
            en_r    <= iisc_pkg::RST_BYTE;
            irq_r   <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            en_r    <= en_nxt;
            irq_r   <= irq_nxt;
        end
    end

    // Address, data and line-state writes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_r       <= iisc_pkg::RST_WORD;
            data_r       <= 16'h0000;
            line_r       <= 2'b00;
            pend_val_r   <= iisc_pkg::RST_WORD;
            pend_op_r    <= iisc_pkg::OP_NONE;
            apply_r      <= 1'b0;
            apply_kind_r <= iisc_pkg::OP_NONE;
        end else begin
            apply_r <= done[iisc_pkg::SB_SYSTEM_OP_BUSY];
            if (go_sys) begin
                pend_val_r <= reg_wdata_i;
                pend_op_r  <= w_status ? iisc_pkg::OP_LINE
                            : (w_addr ? iisc_pkg::OP_ADDR : iisc_pkg::OP_DATA);
            end
            // Slave-role address and data need no synchronisation
            if (!is_master && w_addr) begin
                addr_r <= reg_wdata_i;
            end
            if (!is_master && w_data) begin
                data_r <= reg_wdata_i[15:0];
            end
            if (done[iisc_pkg::SB_SYSTEM_OP_BUSY]) begin
                apply_kind_r <= pend_op_r;
                case (pend_op_r)
                    iisc_pkg::OP_LINE:
                        line_r <= pend_val_r[iisc_pkg::ST_LINE_LO +: 2];
                    iisc_pkg::OP_ADDR: addr_r <= pend_val_r;
                    iisc_pkg::OP_DATA: data_r <= pend_val_r[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Bus answer and sleep outputs
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r  <= iisc_pkg::RST_WORD;
            err_r    <= 1'b0;
            ck_r     <= iisc_pkg::CK_RUN;
            clkreq_r <= 1'b1;
            wake_r   <= 1'b0;
            drop_r   <= 1'b0;
        end else begin
            rdata_r  <= reg_re_i ? rd_mux : iisc_pkg::RST_WORD;
            err_r    <= err_any;
            ck_r     <= ck_nxt;
            clkreq_r <= clkreq_nxt;
            wake_r   <= wake_nxt;
            drop_r   <= drop_nxt;
        end
    end

    assign reg_rdata_o        = rdata_r;
    assign bus_err_o          = err_r;
    assign irq_o              = irq_r;
    assign wake_o             = wake_r;
    assign core_clock_req_o   = clkreq_r;
    assign rx_drop_o          = drop_r;
    assign enabled_o          = enable_r;
    assign control_main_o     = ctrl_word;
    assign control_sec_o      = ctrl2_r;
    assign addr_o             = addr_r;
    assign data_o             = data_r;
    assign line_state_field_o = line_r;
    assign system_op_busy_apply_o      = apply_r;
    assign system_op_busy_kind_o       = apply_kind_r;

    chk_addr_hit_flag_sets: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (is_slave && evt_i.addr_hit_flag && !soft_reset_done)
            |=> flags_r[iisc_pkg::FL_ADDR_HIT_FLAG])
        else $error("address match event did not set its flag");

    chk_irq_follows: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        irq_o == |(flags_r & en_r))
        else $error("interrupt line disagrees with flags and enables");

    chk_enset_bit: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (w_enset && reg_wdata_i[0] && !soft_reset_done) |=> en_r[0])
        else $error("enable set write did not enable");

    chk_enclr_bit: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (w_enclr && reg_wdata_i[0]) |=> !en_r[0])
        else $error("enable clear write did not disable");

    chk_flag_w1c: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (w_flags && reg_wdata_i[7] && !evt_i.error && (is_slave || is_master))
            |=> !flags_r[7])
        else $error("write one did not clear error flag");

    chk_enable_busy: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (go_en && !go_rst) |=> busy[iisc_pkg::SB_ENABLE] [*4]
            ##1 !busy[iisc_pkg::SB_ENABLE])
        else $error("enable busy length wrong");

    chk_busy_error: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (sys_wr && busy[iisc_pkg::SB_SYSTEM_OP_BUSY]) |=> bus_err_o)
        else $error("write while busy gave no bus error");

    chk_soft_reset_clears: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        // Four busy cycles at the default sync length, then one to apply
        go_rst |=> ##4 (flags_r == 8'h00 && en_r == 8'h00 && !irq_o))
        else $error("soft reset did not clear interrupt state");

    chk_slave_drop: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        slave_hold |=> rx_drop_o && !core_clock_req_o)
        else $error("slave standby did not drop receptions");

    chk_drain_clock: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (master_hold && sleep_i.xfer_busy) |=> core_clock_req_o)
        else $error("core clock stopped during a transaction");

    chk_idle_clock: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (is_master && !sleep_i.standby) |=> core_clock_req_o)
        else $error("master stopped core clock outside standby");

endmodule

// ### iisc_engine_model.sv
// Behavioural model of the protocol engine facing the flag and sleep logic.
// Assumes the bench calls its tasks; outputs change just after a clock edge.
`timescale 1ns/1ns
module iisc_engine_model (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    output iisc_pkg::iisc_evt_t   evt_o,
    output iisc_pkg::iisc_sleep_t sleep_o,
    output logic [15:0]           status_o,
    output logic [7:0]            rx_data_o
);
    // Status pattern with both line state bits clear, so a written state shows
    initial begin
        evt_o = '0;
        sleep_o = '0;
        status_o = 16'h00C3;
        rx_data_o = 8'h5A;
    end

    // Bus conditions arrive as single-cycle pulses, one per occurrence
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_i);
        evt_o <= iisc_pkg::iisc_evt_t'(m);
        @(posedge clk_i);
        evt_o <= '0;
    endtask

    // The transfer busy level holds the core clock in master standby until it drops
    task automatic set_sleep(input logic [2:0] s);
        @(posedge clk_i);
        sleep_o <= iisc_pkg::iisc_sleep_t'(s);
    endtask

    // Engine status and received byte change between bus accesses
    task automatic set_status(input logic [15:0] s, input logic [7:0] d);
        @(posedge clk_i);
        status_o <= s;
        rx_data_o <= d;
    endtask
endmodule

// ### tb.sv
// Self-checking bench of the two-wire unit's flag, sleep and sync logic.
// Assumes the engine model drives events, sleep levels, status and rx byte.
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t: got %0h exp %0h", $time, a, e); end end
module tb;
    localparam int SL = 4;
    logic                  clk;
    logic                  rst;
    logic [5:0]            addr;
    logic [31:0]           wdata;
    logic                  we;
    logic                  re;
    logic [31:0]           rdata, ctl_m, ctl_s, addr_q;
    logic [15:0]           data_q, status;
    logic [7:0]            rx;
    logic [1:0]            line_q;
    logic                  bus_err, irq, wake, ck_req, drop, en, apply;
    iisc_pkg::iisc_op_t    kind;
    iisc_pkg::iisc_evt_t   evt;
    iisc_pkg::iisc_sleep_t slp;
    int                    n_errors = 0;
    int                    checked = 0;
    int                    cycles = 0;
    logic [5:0]  ofs [10] = '{6'h00, 6'h04, 6'h14, 6'h16, 6'h18, 6'h1A,
                              6'h1C, 6'h24, 6'h28, 6'h08};
    logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hC3,
                             32'h0, 32'h0, 32'h5A, 32'h0};

    iisc_ctrl #(.SYNC_LEN(SL)) iisc_ctrl_inst (
        .clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .bus_err_o(bus_err), .evt_i(evt),
        .sleep_i(slp), .status_i(status), .rx_data_i(rx), .irq_o(irq),
        .wake_o(wake), .core_clock_req_o(ck_req), .rx_drop_o(drop),
        .enabled_o(en), .control_main_o(ctl_m), .control_sec_o(ctl_s),
        .addr_o(addr_q), .data_o(data_q), .line_state_field_o(line_q),
        .system_op_busy_apply_o(apply), .system_op_busy_kind_o(kind)
    );
    iisc_engine_model iisc_engine_model_inst (
        .clk_i(clk), .sys_rst_i(rst), .evt_o(evt), .sleep_o(slp),
        .status_o(status), .rx_data_o(rx)
    );

    always #5 clk = ~clk;

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Generous ceiling: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    task automatic done(input string s);
        $display("test %s done, %0d mismatches so far", s, n_errors);
    endtask

    // Soft reset, then mode word with enable; both go through the sync path
    task automatic setup(input logic [31:0] w);
        iisc_engine_model_inst.set_sleep(3'h0);
        wr(iisc_pkg::OFS_CTRL_MAIN, 32'h0000_0001);
        rd(iisc_pkg::OFS_SYNC, 32'h0000_0001);
        cyc(SL + 1);
        `CHK(irq, 1'b0)
        `CHK(ctl_s, 32'h0000_0000)
        rd(iisc_pkg::OFS_FLAGS, 32'h0000_0000);
        wr(iisc_pkg::OFS_CTRL_MAIN, w);
        rd(iisc_pkg::OFS_SYNC, 32'h0000_0002);
        cyc(SL + 1);
        `CHK(en, 1'b1)
        `CHK(ctl_m, w)
    endtask

    // One source: raises the shared line, flag read names it and clears it
    task automatic src(input logic [5:0] m, input logic [31:0] f);
        iisc_engine_model_inst.pulse(m);
        cyc(2);
        `CHK(irq, 1'b1)
        rd(iisc_pkg::OFS_FLAGS, f);
        cyc(1);
        `CHK(irq, 1'b0)
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = 6'h00;
        wdata = 32'h0000_0000;
        we = 1'b0;
        re = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        foreach (ofs[i]) rd(ofs[i], rv[i]);
        done("reset");
        setup(32'h0000_0012);
        wr(iisc_pkg::OFS_EN_SET, 32'h0000_0087);
        wr(iisc_pkg::OFS_EN_SET, 32'h0000_0000);
        rd(iisc_pkg::OFS_EN_CLR, 32'h0000_0087);
        src(6'h20, 32'h0000_0080);
        src(6'h10, 32'h0000_0004);
        src(6'h08, 32'h0000_0002);
        src(6'h04, 32'h0000_0001);
        iisc_engine_model_inst.pulse(6'h08);
        cyc(2);
        wr(iisc_pkg::OFS_FLAGS, 32'h0000_0004);
        cyc(1);
        `CHK(irq, 1'b1)
        wr(iisc_pkg::OFS_FLAGS, 32'h0000_0002);
        cyc(1);
        `CHK(irq, 1'b0)
        iisc_engine_model_inst.pulse(6'h20);
        cyc(2);
        wr(iisc_pkg::OFS_FLAGS, 32'h0000_0080);
        cyc(1);
        `CHK(irq, 1'b0)
        iisc_engine_model_inst.pulse(6'h04);
        cyc(2);
        wr(iisc_pkg::OFS_EN_CLR, 32'h0000_0001);
        cyc(1);
        `CHK(irq, 1'b0)
        rd(iisc_pkg::OFS_FLAGS, 32'h0000_0001);
        rd(iisc_pkg::OFS_EN_SET, 32'h0000_0086);
        iisc_engine_model_inst.set_sleep(3'h2);
        cyc(2);
        `CHK(drop, 1'b1)
        `CHK(ck_req, 1'b0)
        done("slave");
        setup(32'h0000_0016);
        wr(iisc_pkg::OFS_EN_SET, 32'h0000_0083);
        wr(iisc_pkg::OFS_CTRL_SEC, 32'h0003_0300);
        `CHK(ctl_s, 32'h0003_0300)
        src(6'h20, 32'h0000_0080);
        src(6'h02, 32'h0000_0002);
        src(6'h01, 32'h0000_0001);
        iisc_engine_model_inst.set_sleep(3'h5);
        cyc(2);
        `CHK(ck_req, 1'b1)
        iisc_engine_model_inst.pulse(6'h01);
        cyc(2);
        `CHK(wake, 1'b1)
        rd(iisc_pkg::OFS_FLAGS, 32'h0000_0001);
        iisc_engine_model_inst.set_sleep(3'h3);
        cyc(3);
        `CHK(ck_req, 1'b1)
        iisc_engine_model_inst.set_sleep(3'h2);
        cyc(2);
        `CHK(ck_req, 1'b0)
        iisc_engine_model_inst.set_sleep(3'h0);
        wr(iisc_pkg::OFS_ADDR, 32'h0000_0155);
        rd(iisc_pkg::OFS_SYNC, 32'h0000_0004);
        cyc(SL - 2);
        `CHK(apply, 1'b1)
        `CHK(addr_q, 32'h0000_0155)
        `CHK(kind, iisc_pkg::OP_ADDR)
        wr(iisc_pkg::OFS_STATUS, 32'h0000_0020);
        wr(iisc_pkg::OFS_DATA, 32'h0000_003C);
        `CHK(bus_err, 1'b1)
        cyc(SL);
        `CHK(line_q, 2'h2)
        `CHK(data_q, 16'h0000)
        rd(iisc_pkg::OFS_STATUS, 32'h0000_00E3);
        iisc_engine_model_inst.set_status(16'hA50F, 8'hC6);
        rd(iisc_pkg::OFS_STATUS, 32'h0000_A52F);
        rd(iisc_pkg::OFS_DATA, 32'h0000_00C6);
        wr(iisc_pkg::OFS_DATA, 32'h0000_003C);
        cyc(SL + 1);
        `CHK(data_q, 16'h003C)
        `CHK(kind, iisc_pkg::OP_DATA)
        done("master");
        setup(32'h0000_0096);
        wr(iisc_pkg::OFS_EN_SET, 32'h0000_0001);
        iisc_engine_model_inst.set_sleep(3'h2);
        cyc(3);
        `CHK(ck_req, 1'b1)
        iisc_engine_model_inst.pulse(6'h01);
        cyc(2);
        `CHK(wake, 1'b1)
        setup(32'h0000_0092);
        wr(iisc_pkg::OFS_EN_SET, 32'h0000_0003);
        iisc_engine_model_inst.set_sleep(3'h2);
        iisc_engine_model_inst.pulse(6'h04);
        cyc(2);
        `CHK(drop, 1'b0)
        `CHK(irq, 1'b1)
        `CHK(wake, 1'b0)
        iisc_engine_model_inst.pulse(6'h08);
        cyc(2);
        `CHK(wake, 1'b1)
        done("standby");
        stop_test();
    end
endmodule
